// >>> rtl/toid_pkg.sv
// Constants shared by the turn-on input detector
package toid_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int unsigned REF_CLK_MHZ = 125;
    localparam int unsigned PB_DEBOUNCE_TIME_US = 30;
    localparam int unsigned USB_DEBOUNCE_TIME_US = 20;
    localparam int unsigned FAULT_RESTART_DELAY_US = 20;
    localparam int unsigned LONG_PRESS_UNIT_MS = 1000;
    localparam logic [15:0] PB_DEBOUNCE_CYC = 16'(PB_DEBOUNCE_TIME_US * REF_CLK_MHZ);
    localparam logic [15:0] USB_DEBOUNCE_CYC = 16'(USB_DEBOUNCE_TIME_US * REF_CLK_MHZ);
    localparam logic [15:0] FAULT_RESTART_CYC = 16'(FAULT_RESTART_DELAY_US * REF_CLK_MHZ);
    localparam int unsigned LONG_PRESS_UNIT_CYC = LONG_PRESS_UNIT_MS * REF_CLK_MHZ * 1000;
    localparam logic [1:0] POR_SAMPLE_CYC = 2'h3;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PCTRL = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_CAUSE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_LOW_CFG = 8'h18;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PCTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [1:0] LOW_CFG_RESET = 2'h0;

    // Interrupt status bit positions
    localparam int unsigned IRQ_W = 8;
    localparam int unsigned IRQ_PB_FALL = 0;
    localparam int unsigned IRQ_PB_RISE = 1;
    localparam int unsigned IRQ_WAKE_FALL = 2;
    localparam int unsigned IRQ_WAKE_RISE = 3;
    localparam int unsigned IRQ_LOW_RISE = 4;
    localparam int unsigned IRQ_LOW_FALL = 5;
    localparam int unsigned IRQ_USB_RISE = 6;
    localparam int unsigned IRQ_USB_FALL = 7;

    // Turn-on cause bit positions
    localparam int unsigned CAUSE_W = 6;
    localparam int unsigned CAUSE_PB = 0;
    localparam int unsigned CAUSE_USB = 1;
    localparam int unsigned CAUSE_WAKE = 2;
    localparam int unsigned CAUSE_AUTO = 3;
    localparam int unsigned CAUSE_PB_POR = 4;
    localparam int unsigned CAUSE_USB_POR = 5;

    localparam int unsigned NUM_PCTRL = 3;
endpackage

// >>> rtl/toid_turn_on_input_detector.sv
// Turn-on input detector: pin conditioning, wake decisions, reset and interrupt pins
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

// ****************************************
// Debounce filter
// ****************************************
module toid_debounce #(
    parameter logic [15:0] CYC = 16'h0004,
    parameter logic INIT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic sampleIn,
    output logic level,
    output logic rise,
    output logic fall
);
    logic [15:0] cnt_q;
    logic done;

    assign done = (sampleIn != level) && (cnt_q == CYC - 16'h0001);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            level <= INIT;
            cnt_q <= 16'h0000;
        end else if (sampleIn == level) begin
            cnt_q <= 16'h0000;
        end else if (done) begin
            level <= sampleIn;
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= done && sampleIn;
            fall <= done && !sampleIn;
        end
    end
endmodule // toid_debounce

// ****************************************
// Top level
// ****************************************
module toid_turn_on_input_detector #(
    parameter int unsigned LONG_PRESS_UNIT = toid_pkg::LONG_PRESS_UNIT_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [toid_pkg::ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic pushbutton_in_n,
    input wire logic wake_pin_n,
    input wire logic usbPresent,
    input wire logic cmpAboveOkRise,
    input wire logic cmpAboveOkFall,
    input wire logic cmpAboveLowRise,
    input wire logic cmpAboveLowFall,
    input wire logic [toid_pkg::NUM_PCTRL-1:0] power_control_inputs,
    input wire logic shared_reset_line_n_in,
    output logic shared_reset_line_n_out,
    output logic shared_reset_line_n_oen,
    output logic irq_out_n_out,
    output logic irq_out_n_oen,
    input wire logic offState,
    input wire logic assertReset,
    input wire logic nvAutoOn,
    input wire logic [1:0] nvLongPressSel,
    input wire logic nvLongPressOffEn,
    input wire logic [1:0] nvSupplyOkRiseSel,
    input wire logic [1:0] nvSupplyOkHystSel,
    output logic [1:0] supply_ok_rise_sel,
    output logic [1:0] supply_ok_hyst_sel,
    output logic turnOnReq,
    output logic longPressOff,
    output logic supplyFaultOff,
    output logic apResetReq,
    output logic powerUpAllowed,
    output logic [toid_pkg::NUM_PCTRL-1:0] pwrCtrlActive
);
    import toid_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int unsigned NSYNC = 9 + NUM_PCTRL;
    localparam logic [NSYNC-1:0] SYNC_IDLE = {{NUM_PCTRL{1'b0}}, 9'h1e3};
    logic [NSYNC-1:0] syncA_q;
    logic [NSYNC-1:0] syncB_q;
    logic pbSync, wakeSync, usbSync, okRiseSync, okFallSync, lowRiseSync, lowFallSync;
    logic rstLineSync;
    logic [NUM_PCTRL-1:0] pctrlSync;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            syncA_q <= SYNC_IDLE;
            syncB_q <= SYNC_IDLE;
        end else begin
            syncA_q <= {power_control_inputs, shared_reset_line_n_in, 1'b0, cmpAboveLowFall,
                        cmpAboveLowRise, cmpAboveOkFall, cmpAboveOkRise, usbPresent,
                        wake_pin_n, pushbutton_in_n};
            syncB_q <= syncA_q;
        end
    end

    assign pbSync = syncB_q[0];
    assign wakeSync = syncB_q[1];
    assign usbSync = syncB_q[2];
    assign okRiseSync = syncB_q[3];
    assign okFallSync = syncB_q[4];
    assign lowRiseSync = syncB_q[5];
    assign lowFallSync = syncB_q[6];
    assign rstLineSync = syncB_q[8];
    assign pctrlSync = syncB_q[NSYNC-1:9];

    // ****************************************
    // Debounced push-button and USB presence
    // ****************************************
    logic pbLevel, pbRise, pbFall, usbLevel, usbRise, usbFall;

    toid_debounce #(.CYC(PB_DEBOUNCE_CYC), .INIT(1'b1)) uPbDeb (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .sampleIn(pbSync),
        .level(pbLevel),
        .rise(pbRise),
        .fall(pbFall)
    );

    toid_debounce #(.CYC(USB_DEBOUNCE_CYC), .INIT(1'b0)) uUsbDeb (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .sampleIn(usbSync),
        .level(usbLevel),
        .rise(usbRise),
        .fall(usbFall)
    );

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] ctrl_q;
    logic [31:0] pctrl_q;
    logic [IRQ_W-1:0] irqStat_q;
    logic [IRQ_W-1:0] irqMask_q;
    logic [1:0] lowCfg_q;
    logic [CAUSE_W-1:0] cause_q;
    logic [IRQ_W-1:0] irqEvent;
    logic wakePrev_q, lowRisePrev_q, lowFallPrev_q;
    logic restartHold;
    logic okLevel_q;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctrl_q <= CTRL_RESET;
            pctrl_q <= PCTRL_RESET;
            irqMask_q <= IRQ_MASK_RESET;
            lowCfg_q <= LOW_CFG_RESET;
        end else if (regWr) begin
            case (regAddr)
                ADDR_CTRL: ctrl_q <= {26'h0000000, regWdata[5:0]};
                ADDR_PCTRL: pctrl_q <= {8'h00, regWdata[23:8], 5'h00, regWdata[2:0]};
                ADDR_IRQ_MASK: irqMask_q <= regWdata[IRQ_W-1:0];
                ADDR_LOW_CFG: lowCfg_q <= regWdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wakePrev_q <= 1'b1;
            lowRisePrev_q <= 1'b1;
            lowFallPrev_q <= 1'b1;
        end else begin
            wakePrev_q <= wakeSync;
            lowRisePrev_q <= lowRiseSync;
            lowFallPrev_q <= lowFallSync;
        end
    end

    always_comb begin
        irqEvent = '0;
        irqEvent[IRQ_PB_FALL] = pbFall;
        irqEvent[IRQ_PB_RISE] = pbRise;
        irqEvent[IRQ_WAKE_FALL] = wakePrev_q && !wakeSync;
        irqEvent[IRQ_WAKE_RISE] = !wakePrev_q && wakeSync;
        irqEvent[IRQ_LOW_RISE] = lowCfg_q[0] && lowRisePrev_q && !lowRiseSync;
        irqEvent[IRQ_LOW_FALL] = lowCfg_q[1] && !lowFallPrev_q && lowFallSync;
        irqEvent[IRQ_USB_RISE] = usbRise;
        irqEvent[IRQ_USB_FALL] = usbFall;
    end

    // Write one to clear; a new event in the same cycle wins over the clear
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irqStat_q <= '0;
        end else if (regWr && regAddr == ADDR_IRQ_STAT) begin
            irqStat_q <= (irqStat_q & ~regWdata[IRQ_W-1:0]) | irqEvent;
        end else begin
            irqStat_q <= irqStat_q | irqEvent;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            regRdata <= 32'h0000_0000;
        end else if (regRd) begin
            case (regAddr)
                ADDR_CTRL: regRdata <= ctrl_q;
                ADDR_PCTRL: regRdata <= pctrl_q;
                ADDR_IRQ_STAT: regRdata <= {24'h000000, irqStat_q};
                ADDR_IRQ_MASK: regRdata <= {24'h000000, irqMask_q};
                ADDR_CAUSE: regRdata <= {26'h0000000, cause_q};
                ADDR_STATUS: regRdata <= {23'h000000, rstLineSync, restartHold,
                                          pwrCtrlActive, okLevel_q, wakeSync, usbLevel, pbLevel};
                ADDR_LOW_CFG: regRdata <= {30'h00000000, lowCfg_q};
                default: regRdata <= 32'h0000_0000;
            endcase
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Open-drain interrupt and reset pins
    // ****************************************
    logic [2:0] driveHist_q;

    assign irq_out_n_out = 1'b0;
    assign irq_out_n_oen = ~(|(irqStat_q & irqMask_q));
    assign shared_reset_line_n_out = 1'b0;
    assign shared_reset_line_n_oen = ~assertReset;

    // The pin echo of our own drive takes the synchroniser delay to clear
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            driveHist_q <= 3'h0;
            apResetReq <= 1'b0;
        end else begin
            driveHist_q <= {driveHist_q[1:0], assertReset};
            apResetReq <= !rstLineSync && !assertReset && driveHist_q == 3'h0;
        end
    end

    // ****************************************
    // Supply-ok monitoring and fault restart delay
    // ****************************************
    logic [15:0] restartCnt_q;

    assign restartHold = restartCnt_q != 16'h0000;
    assign powerUpAllowed = okLevel_q && !restartHold;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            supply_ok_rise_sel <= 2'h0;
            supply_ok_hyst_sel <= 2'h0;
        end else begin
            supply_ok_rise_sel <= nvSupplyOkRiseSel;
            supply_ok_hyst_sel <= nvSupplyOkHystSel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            okLevel_q <= 1'b0;
            supplyFaultOff <= 1'b0;
            restartCnt_q <= 16'h0000;
        end else begin
            if (okRiseSync) begin
                okLevel_q <= 1'b1;
            end else if (!okFallSync) begin
                okLevel_q <= 1'b0;
            end
            supplyFaultOff <= okLevel_q && !okRiseSync && !okFallSync && !offState;
            if (okLevel_q && !okRiseSync && !okFallSync && !offState) begin
                restartCnt_q <= FAULT_RESTART_CYC;
            end else if (restartHold) begin
                restartCnt_q <= restartCnt_q - 16'h0001;
            end
        end
    end

    // ****************************************
    // Long press
    // ****************************************
    logic [31:0] unitCnt_q;
    logic [4:0] lpUnits_q;
    logic lpFired_q;
    logic [3:0] lpDur;

    assign lpDur = ctrl_q[4] ? ctrl_q[3:0] : {2'h0, nvLongPressSel};

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            unitCnt_q <= 32'h0000_0000;
            lpUnits_q <= 5'h00;
            lpFired_q <= 1'b0;
            longPressOff <= 1'b0;
        end else if (pbLevel) begin
            unitCnt_q <= 32'h0000_0000;
            lpUnits_q <= 5'h00;
            lpFired_q <= 1'b0;
            longPressOff <= 1'b0;
        end else begin
            if (unitCnt_q == LONG_PRESS_UNIT - 1) begin
                unitCnt_q <= 32'h0000_0000;
                if (!lpFired_q) begin
                    lpUnits_q <= lpUnits_q + 5'h01;
                end
            end else begin
                unitCnt_q <= unitCnt_q + 32'h0000_0001;
            end
            longPressOff <= !lpFired_q && (ctrl_q[5] || nvLongPressOffEn)
                            && lpUnits_q == {1'b0, lpDur} + 5'h01;
            if (lpUnits_q == {1'b0, lpDur} + 5'h01) begin
                lpFired_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // Power-control inputs
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PCTRL; gi++) begin : gPctrl
            logic [7:0] dlyCnt_q;
            logic raw;
            assign raw = pctrlSync[gi] ^ pctrl_q[gi];
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    pwrCtrlActive[gi] <= 1'b0;
                    dlyCnt_q <= 8'h00;
                end else if (raw == pwrCtrlActive[gi]) begin
                    dlyCnt_q <= 8'h00;
                end else if (dlyCnt_q >= (raw ? pctrl_q[15:8] : pctrl_q[23:16])) begin
                    pwrCtrlActive[gi] <= raw;
                    dlyCnt_q <= 8'h00;
                end else begin
                    dlyCnt_q <= dlyCnt_q + 8'h01;
                end
            end
        end
    endgenerate

    // ****************************************
    // Turn-on decision and cause
    // ****************************************
    logic [1:0] porCnt_q;
    logic porSample;
    logic [CAUSE_W-1:0] onCause;

    // Synchronisers need their two edges before the power-on levels are valid
    assign porSample = porCnt_q == POR_SAMPLE_CYC - 2'h1;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            porCnt_q <= 2'h0;
        end else if (porCnt_q != POR_SAMPLE_CYC) begin
            porCnt_q <= porCnt_q + 2'h1;
        end
    end

    always_comb begin
        onCause = '0;
        if (porSample) begin
            onCause[CAUSE_PB_POR] = !pbSync;
            onCause[CAUSE_USB_POR] = usbSync;
            onCause[CAUSE_AUTO] = nvAutoOn;
            onCause[CAUSE_WAKE] = !wakeSync;
        end else if (offState) begin
            onCause[CAUSE_PB] = pbFall;
            onCause[CAUSE_USB] = usbRise;
            onCause[CAUSE_WAKE] = !wakeSync;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            turnOnReq <= 1'b0;
            cause_q <= '0;
        end else begin
            turnOnReq <= |onCause;
            if (|onCause) begin
                cause_q <= onCause;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence pbStartLow;
        pbLevel && !pbSync;
    endsequence
    sequence faultSeen;
        $rose(supplyFaultOff);
    endsequence

    AST_PB_BOUNCE: assert property (pbStartLow
        |=> pbLevel || $past(uPbDeb.cnt_q) == PB_DEBOUNCE_CYC - 16'h0001)
        else $error("Push-button level changed without debounce time");
    AST_PB_RISE_HOLD: assert property (!pbLevel && pbSync
        |=> !pbLevel || $past(uPbDeb.cnt_q) == PB_DEBOUNCE_CYC - 16'h0001)
        else $error("Push-button release not debounced");
    AST_PB_FALL_IRQ: assert property (pbFall |=> irqStat_q[IRQ_PB_FALL])
        else $error("Push-button fall did not set its interrupt");
    AST_WAKE_ON: assert property (offState && !wakeSync |=> turnOnReq && cause_q[CAUSE_WAKE])
        else $error("Wake low in off state did not turn on");
    AST_WAKE_IRQ: assert property (wakePrev_q && !wakeSync |=> irqStat_q[IRQ_WAKE_FALL])
        else $error("Wake fall did not set its interrupt");
    AST_ON_GATED: assert property (turnOnReq |-> $past(offState) || $past(porSample))
        else $error("Turn-on outside off or power-on window");
    AST_CAUSE_SET: assert property (turnOnReq |-> cause_q != '0)
        else $error("Turn-on without a cause bit");
    AST_IRQ_PIN: assert property ($rose(irqStat_q[IRQ_USB_RISE]) && irqMask_q[IRQ_USB_RISE]
        |-> !irq_out_n_oen)
        else $error("Unmasked interrupt did not pull the pin");
    AST_FAULT_HOLD: assert property (faultSeen |-> restartHold [*8])
        else $error("Restart hold ended too early after supply fault");
    AST_LP_LOW: assert property (longPressOff |-> $past(!pbLevel))
        else $error("Long press fired with button released");
    AST_AP_RESET: assert property (apResetReq |-> !$past(assertReset, 2))
        else $error("Power cycle request while driving reset");
endmodule // toid_turn_on_input_detector

// >>> testbench/toid_ap_model.sv
// Processor-side model of the shared reset and interrupt wires
`timescale 1ns/1ns
module toid_ap_model (
    input wire logic pullRst,
    input wire logic rstOut,
    input wire logic rstOen,
    input wire logic irqOut,
    input wire logic irqOen,
    output logic rstLine,
    output logic irqLine
);
    // Pull-ups hold both wires high unless a party sinks them
    // Processor sinks reset only while the device leaves it undriven
    assign rstLine = ((!rstOen && !rstOut) || (rstOen && pullRst)) ? 1'b0 : 1'b1;
    assign irqLine = (!irqOen && !irqOut) ? 1'b0 : 1'b1;
endmodule // toid_ap_model

// >>> testbench/tb.sv
// Self-checking bench for the turn-on input detector
`timescale 1ns/1ns
module tb;
    import toid_pkg::*;
    logic ref_clk, resetn, regWr, regRd, pbN, wakeN, usb, okR, okF, lowR, lowF;
    logic offState, assertReset, pullRst, rstLine, irqLine, rstOut, rstOen, irqOut, irqOen;
    logic apReq, tOn, lpOff, fltOff, upOk, nvAuto, nvLpEn;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, seed;
    logic [2:0] pwrIn, pwrAct;
    logic [1:0] riseSel, hystSel;
    int error_cnt, cmp_count, cyc, onCnt, lpCnt, fltCnt;

    toid_turn_on_input_detector #(.LONG_PRESS_UNIT(16)) i_toid_turn_on_input_detector (
        .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pushbutton_in_n(pbN),
        .wake_pin_n(wakeN), .usbPresent(usb), .cmpAboveOkRise(okR), .cmpAboveOkFall(okF),
        .cmpAboveLowRise(lowR), .cmpAboveLowFall(lowF), .power_control_inputs(pwrIn),
        .shared_reset_line_n_in(rstLine), .shared_reset_line_n_out(rstOut),
        .shared_reset_line_n_oen(rstOen), .irq_out_n_out(irqOut), .irq_out_n_oen(irqOen),
        .offState(offState), .assertReset(assertReset), .nvAutoOn(nvAuto),
        .nvLongPressSel(2'h0), .nvLongPressOffEn(nvLpEn), .nvSupplyOkRiseSel(2'h2),
        .nvSupplyOkHystSel(2'h1), .supply_ok_rise_sel(riseSel), .supply_ok_hyst_sel(hystSel),
        .turnOnReq(tOn), .longPressOff(lpOff), .supplyFaultOff(fltOff), .apResetReq(apReq),
        .powerUpAllowed(upOk), .pwrCtrlActive(pwrAct));

    toid_ap_model i_toid_ap_model (.pullRst(pullRst), .rstOut(rstOut), .rstOen(rstOen),
        .irqOut(irqOut), .irqOen(irqOen), .rstLine(rstLine), .irqLine(irqLine));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Event counters double as the bench's model of pulse outputs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (resetn) begin
            onCnt <= onCnt + int'(tOn);
            lpCnt <= lpCnt + int'(lpOff);
            fltCnt <= fltCnt + int'(fltOff);
        end
        if (cyc == 60000) begin
            error_cnt++;
            finish_test();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string w);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        cmp(w, e, regRdata & m);
    endtask
    task automatic bounce(input logic v);
        pbN <= v;
        tk(1000);
        pbN <= ~v;
        tk(1);
        pbN <= v;
        tk(3000);
        rd(ADDR_STATUS, 32'h1, {31'h0, ~v}, "button level before settle");
        tk(1000);
        rd(ADDR_STATUS, 32'h1, {31'h0, v}, "button level settled");
    endtask
    task automatic endt(input string n);
        $display("test %s done", n);
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {error_cnt, cmp_count, cyc, onCnt, lpCnt, fltCnt} = '0;
        {resetn, pbN, wakeN, usb, okR, okF, lowR, lowF} = 8'h3f;
        {offState, assertReset, pullRst, pwrIn, regWr, regRd, regAddr, regWdata} = '0;
        seed = 32'h403ebd2b;
        {nvAuto, nvLpEn} = 2'b11;
        tk(2);
        resetn <= 1'b1;
        tk(10);
        cmp("power-on turn-on count", 32'h1, onCnt);
        cmp("supply ok selects", 32'h9, {28'h0, riseSel, hystSel});
        cmp("power control default", 32'h0, {29'h0, pwrAct});
        rd(ADDR_CAUSE, 32'h3f, 32'h38, "power-on cause");
        rd(8'h40, 32'hffffffff, 32'h0, "unmapped read");
        endt("power-on");
        tk(4000);
        cmp("nv long press count", 32'h1, lpCnt);
        wr(ADDR_IRQ_STAT, 32'hff);
        bounce(1'b1);
        rd(ADDR_IRQ_STAT, 32'h3, 32'h2, "button rise event");
        offState <= 1'b1;
        wr(ADDR_CTRL, 32'h32);
        wr(ADDR_IRQ_STAT, 32'hff);
        bounce(1'b0);
        cmp("button turn-on count", 32'h2, onCnt);
        rd(ADDR_CAUSE, 32'h3f, 32'h1, "button cause");
        rd(ADDR_IRQ_STAT, 32'h3, 32'h1, "button fall event");
        cmp("long press count", 32'h2, lpCnt);
        endt("button");
        wakeN <= 1'b0;
        tk(1);
        wakeN <= 1'b1;
        tk(10);
        cmp("wake turn-on count", 32'h3, onCnt);
        rd(ADDR_CAUSE, 32'h3f, 32'h4, "wake cause");
        rd(ADDR_IRQ_STAT, 32'hc, 32'hc, "wake events");
        offState <= 1'b0;
        wakeN <= 1'b0;
        tk(1);
        wakeN <= 1'b1;
        tk(10);
        cmp("turn-on outside off", 32'h3, onCnt);
        #1;
        cmp("irq line masked", 32'h1, {31'h0, irqLine});
        wr(ADDR_IRQ_MASK, 32'h4);
        #1;
        cmp("irq line pending", 32'h0, {31'h0, irqLine});
        wr(ADDR_IRQ_STAT, 32'h4);
        #1;
        cmp("irq line cleared", 32'h1, {31'h0, irqLine});
        endt("wake and irq");
        assertReset <= 1'b1;
        tk(1);
        #1;
        cmp("reset line driven", 32'h0, {31'h0, rstLine});
        assertReset <= 1'b0;
        pullRst <= 1'b1;
        tk(6);
        #1;
        cmp("processor reset request", 32'h1, {31'h0, apReq});
        pullRst <= 1'b0;
        tk(6);
        #1;
        cmp("reset request gone", 32'h0, {31'h0, apReq});
        endt("reset line");
        wr(ADDR_LOW_CFG, 32'h3);
        wr(ADDR_IRQ_STAT, 32'hff);
        lowR <= 1'b0;
        tk(5);
        lowF <= 1'b0;
        tk(5);
        lowF <= 1'b1;
        tk(5);
        lowR <= 1'b1;
        tk(5);
        rd(ADDR_IRQ_STAT, 32'hff, 32'h30, "supply low events");
        {okR, okF} <= 2'b00;
        tk(10);
        {okR, okF} <= 2'b11;
        tk(2400);
        #1;
        cmp("restart held", 32'h0, {31'h0, upOk});
        cmp("fault off count", 32'h1, fltCnt);
        tk(200);
        #1;
        cmp("restart released", 32'h1, {31'h0, upOk});
        endt("supply");
        offState <= 1'b1;
        usb <= 1'b0;
        tk(2700);
        wr(ADDR_IRQ_STAT, 32'hff);
        wr(ADDR_IRQ_MASK, 32'h40);
        usb <= 1'b1;
        tk(2000);
        rd(ADDR_STATUS, 32'h2, 32'h0, "usb before settle");
        tk(700);
        rd(ADDR_STATUS, 32'h2, 32'h2, "usb settled");
        rd(ADDR_CAUSE, 32'h3f, 32'h2, "usb cause");
        rd(ADDR_IRQ_STAT, 32'hc0, 32'h40, "usb rise event");
        cmp("irq line usb", 32'h0, {31'h0, irqLine});
        endt("usb");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(ADDR_PCTRL, {8'h00, 8'h04, 8'h04, 5'h00, seed[2:0]});
            pwrIn <= seed[5:3];
            tk(20);
            cmp("power control level", {29'h0, seed[5:3] ^ seed[2:0]}, {29'h0, pwrAct});
        end
        endt("power control");
        finish_test();
    end
endmodule // tb
